// *** logic/slave_port_device.sv ***
// Slave end: port registers, attention line and command dispatch
`timescale 1ns/1ps
// Overview of operation
// - Slave only answers commands master sent
// - Master loads channel, data, then command
// - Write address 0 stores command, starts dispatch
// - Slave sets return data and response in the same cycle
// - Attention low on response until cleared
// - Status bit 3 set on response
// - Any write to address 3 clears
// - Master reads results before next command
// - Four addresses, separate read/write registers
// - Write address 1 selects channel
// - Address 2 returns or stores data
// - Read 3 status, read 0 response
// - Status flags which registers were updated
// - Master holds chip select during access
// - Write strobe writes, read strobe reads
// - Two address bits, eight data bits
// - 256 channels, each with own handler
// - Polled or interrupt dispatch, two flavours
// - Exactly one prompt response per command
// - Master polls bit 3 or uses attention
module slave_port_device
  import slave_port_pkg::*;
#(
  parameter int CHANNELS = 256
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // Strobe bus
  slave_port_if.slave     port,
  // Driver setup and handler registration
  input  wire logic [1:0] driver_setup,
  input  wire logic       poll_service,
  input  wire logic       handler_register,
  input  wire logic [7:0] handler_channel,
  input  wire logic       handler_enable,
  // Command towards the handler
  output logic            cmd_valid,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_channel,
  output logic [7:0]      cmd_data,
  output logic            cmd_interruptible,
  // Answer from the handler
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_code,
  input  wire logic [7:0] resp_data,
  input  wire logic       resp_has_data
);
  import slave_port_pkg::*;

  // Write-side registers filled by the master
  logic [7:0] cmd_in_r;
  logic [7:0] chan_in_r;
  logic [7:0] data_in_r;
  // Read-side registers filled by the slave
  logic [7:0] resp_out_r;
  logic [7:0] data_out_r;
  logic [3:0] flags_r;
  logic       attn_r;
  // Strobe sampling
  logic       wr_prev_r;
  logic       cs_prev_r;
  logic [1:0] addr_cap_r;
  logic [7:0] data_cap_r;
  logic       rd_oe_r;
  logic [7:0] rd_data_r;
  // Dispatch state
  logic       pending_r;
  logic       busy_r;
  logic       cmd_valid_r;
  logic [7:0] cmd_code_r;
  logic [7:0] cmd_chan_r;
  logic [7:0] cmd_data_r;
  logic       cmd_int_r;
  logic       present;
  logic [1:0] addr_now;
  logic       wr_commit;
  logic       go;
  logic       answer;
  logic       no_handler;

  // Read mux for the master side
  function automatic logic [7:0] read_sel(input logic [1:0] a,
                                          input logic [7:0] resp,
                                          input logic [7:0] dat,
                                          input logic [3:0] fl);
    logic [7:0] v;
    v = BYTE_RST;
    case (a)
      ADDR_CMD_RESP: v = resp;
      ADDR_DATA:     v = dat;
      ADDR_FLAGS:    v = {4'h0, fl};
      default:       v = BYTE_RST;
    endcase
    return v;
  endfunction

  assign addr_now = {port.reg_addr_high, port.reg_addr_low};
  // Write commits on rising write strobe
  assign wr_commit = !wr_prev_r && port.write_strobe_n && !cs_prev_r;

  channel_table #(
    .CHANNELS (CHANNELS)
  ) u_table (
    .clock        (clock),
    .arst_n       (arst_n),
    .ce           (ce),
    .reg_we       (handler_register),
    .reg_channel  (handler_channel),
    .reg_enable   (handler_enable),
    .look_channel (chan_in_r),
    .look_present (present)
  );

  assign go = pending_r && !busy_r &&
              ((driver_setup != MODE_POLL) || poll_service);
  assign no_handler = go && !present;
  assign answer = (busy_r && resp_valid) || no_handler;

  // Strobe and address sampling
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_prev_r  <= 1'b1;
      cs_prev_r  <= 1'b1;
      addr_cap_r <= 2'h0;
      data_cap_r <= BYTE_RST;
    end else if (ce) begin
      wr_prev_r <= port.write_strobe_n;
      cs_prev_r <= port.cs_n;
      if (!port.cs_n && !port.write_strobe_n) begin
        addr_cap_r <= addr_now;
        data_cap_r <= port.data_bus;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_in_r  <= BYTE_RST;
      chan_in_r <= BYTE_RST;
      data_in_r <= BYTE_RST;
    end else if (ce && wr_commit) begin
      case (addr_cap_r)
        ADDR_CMD_RESP: cmd_in_r <= data_cap_r;
        ADDR_CHANNEL:  chan_in_r <= data_cap_r;
        ADDR_DATA:     data_in_r <= data_cap_r;
        default:       ;
      endcase
    end
  end

  // Pending only after a master command
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pending_r <= 1'b0;
    end else if (ce) begin
      if (wr_commit && addr_cap_r == ADDR_CMD_RESP) begin
        pending_r <= 1'b1;
      end else if (go) begin
        pending_r <= 1'b0;
      end
    end
  end

  // Handover of a command to its handler
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_r      <= 1'b0;
      cmd_valid_r <= 1'b0;
      cmd_code_r  <= BYTE_RST;
      cmd_chan_r  <= BYTE_RST;
      cmd_data_r  <= BYTE_RST;
      cmd_int_r   <= 1'b0;
    end else if (ce) begin
      if (go && present) begin
        busy_r      <= 1'b1;
        cmd_valid_r <= 1'b1;
        cmd_code_r  <= cmd_in_r;
        cmd_chan_r  <= chan_in_r;
        cmd_data_r  <= data_in_r;
        // Mode 1 lets handler be interrupted
        cmd_int_r   <= (driver_setup == MODE_IRQ);
      end else if (busy_r && resp_valid) begin
        busy_r      <= 1'b0;
        cmd_valid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resp_out_r <= BYTE_RST;
      data_out_r <= BYTE_RST;
    end else if (ce && answer) begin
      resp_out_r <= no_handler ? NO_HANDLER_RESP : resp_code;
      if (!no_handler && resp_has_data) begin
        data_out_r <= resp_data;
      end
    end
  end

  // Update flags; set wins over clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= 4'h0;
    end else if (ce) begin
      if (go) begin
        flags_r[FLAG_CMD]  <= 1'b0;
        flags_r[FLAG_CHAN] <= 1'b0;
        flags_r[FLAG_DATA] <= 1'b0;
      end
      if (wr_commit && addr_cap_r == ADDR_CMD_RESP) begin
        flags_r[FLAG_CMD] <= 1'b1;
      end
      if (wr_commit && addr_cap_r == ADDR_CHANNEL) begin
        flags_r[FLAG_CHAN] <= 1'b1;
      end
      if (wr_commit && addr_cap_r == ADDR_DATA) begin
        flags_r[FLAG_DATA] <= 1'b1;
      end
      // Any write to address 3 clears
      if (wr_commit && addr_cap_r == ADDR_FLAGS) begin
        flags_r[FLAG_RESP] <= 1'b0;
      end
      if (answer) begin
        flags_r[FLAG_RESP] <= 1'b1;
      end
    end
  end

  // Attention line follows the response flag
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      attn_r <= ATTN_IDLE;
    end else if (ce) begin
      // Pulled low on response, set wins
      if (answer) begin
        attn_r <= 1'b0;
      end else if (wr_commit && addr_cap_r == ADDR_FLAGS) begin
        attn_r <= ATTN_IDLE;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_oe_r   <= 1'b0;
      rd_data_r <= BYTE_RST;
    end else if (ce) begin
      rd_oe_r   <= !port.cs_n && !port.read_strobe_n;
      rd_data_r <= read_sel(addr_now, resp_out_r, data_out_r, flags_r);
    end
  end

  // Pin and user-side outputs
  assign port.s_data_out      = rd_data_r;
  assign port.s_data_oe       = rd_oe_r;
  assign port.attention_pin_n = attn_r;
  assign cmd_valid            = cmd_valid_r;
  assign cmd_code             = cmd_code_r;
  assign cmd_channel          = cmd_chan_r;
  assign cmd_data             = cmd_data_r;
  assign cmd_interruptible    = cmd_int_r;
endmodule

// *** logic/slave_port_pkg.sv ***
// Shared constants for the slave port device and its master controller
package slave_port_pkg;
  // Slave port register addresses
  localparam logic [1:0] ADDR_CMD_RESP = 2'h0;
  localparam logic [1:0] ADDR_CHANNEL  = 2'h1;
  localparam logic [1:0] ADDR_DATA     = 2'h2;
  localparam logic [1:0] ADDR_FLAGS    = 2'h3;
  // Update flag bit positions
  localparam int FLAG_CMD  = 0;
  localparam int FLAG_CHAN = 1;
  localparam int FLAG_DATA = 2;
  localparam int FLAG_RESP = 3;
  // Reset values
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic       ATTN_IDLE = 1'b1;
  localparam logic [7:0] BUS_IDLE  = 8'hff;
  localparam logic [7:0] NO_HANDLER_RESP = 8'h00;
  // Command detection modes
  localparam logic [1:0] MODE_POLL   = 2'h0;
  localparam logic [1:0] MODE_IRQ    = 2'h1;
  localparam logic [1:0] MODE_IRQ_NI = 2'h2;
  // Strobe timing of the master
  localparam int CLK_NS    = 40;
  localparam int SETUP_NS  = 40;
  localparam int STROBE_NS = 80;
  localparam int HOLD_NS   = 40;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_LEN  = SETUP_CYC + STROBE_CYC + HOLD_CYC;
  // Master controller APB map
  localparam logic [7:0] APB_CMD    = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_RESULT = 8'h08;
  localparam int CMD_GO_BIT   = 31;
  localparam int CMD_POLL_BIT = 25;
  localparam int CMD_DATA_BIT = 24;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ATTN = 2;
endpackage

// *** logic/slave_port_if.sv ***
// Parallel strobe bus between master controller and slave port
`timescale 1ns/1ps
interface slave_port_if;
  logic       cs_n;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic       reg_addr_low;
  logic       reg_addr_high;
  logic [7:0] m_data_out;
  logic       m_data_oe;
  logic [7:0] s_data_out;
  logic       s_data_oe;
  logic       attention_pin_n;
  logic [7:0] data_bus;

  // Resolved level of the shared data bus
  assign data_bus = m_data_oe ? m_data_out :
                    (s_data_oe ? s_data_out : 8'hff);

  modport master (output cs_n, write_strobe_n, read_strobe_n,
                  reg_addr_low, reg_addr_high, m_data_out, m_data_oe,
                  input data_bus, attention_pin_n);
  modport slave (input cs_n, write_strobe_n, read_strobe_n,
                 reg_addr_low, reg_addr_high, data_bus,
                 output s_data_out, s_data_oe, attention_pin_n);
endinterface

// *** logic/channel_table.sv ***
// Table of channels that have a command handler attached
`timescale 1ns/1ps
module channel_table #(
  parameter int CHANNELS = 256
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // Handler registration
  input  wire logic       reg_we,
  input  wire logic [7:0] reg_channel,
  input  wire logic       reg_enable,
  // Lookup
  input  wire logic [7:0] look_channel,
  output logic            look_present
);
  logic [CHANNELS-1:0] present_r;

  // Registration bitmap
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      present_r <= '0;
    end else if (ce && reg_we) begin
      present_r[reg_channel] <= reg_enable;
    end
  end

  assign look_present = present_r[look_channel];
endmodule

// *** logic/slave_port_host.sv ***
// Master end: runs one command exchange ordered over APB
`timescale 1ns/1ps
module slave_port_host
  import slave_port_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Strobe bus
  slave_port_if.master     port
);
  import slave_port_pkg::*;

  typedef enum logic [8:0] {
    H_IDLE = 9'b0_0000_0001,
    H_CHAN = 9'b0_0000_0010,
    H_DATA = 9'b0_0000_0100,
    H_CMD  = 9'b0_0000_1000,
    H_WAIT = 9'b0_0001_0000,
    H_POLL = 9'b0_0010_0000,
    H_RESP = 9'b0_0100_0000,
    H_RDAT = 9'b0_1000_0000,
    H_CLR  = 9'b1_0000_0000
  } host_state_e;

  host_state_e state_r;
  host_state_e state_nxt;
  logic [31:0] cmd_r;
  logic        done_r;
  logic [7:0]  resp_r;
  logic [7:0]  rdat_r;
  logic [3:0]  cnt_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        cs_n_r;
  logic        wr_n_r;
  logic        rd_n_r;
  logic [1:0]  addr_r;
  logic [7:0]  wdat_r;
  logic        oe_r;
  logic        on_bus;
  logic        is_rd;
  logic [1:0]  op_addr;
  logic        op_end;
  logic        sample;
  logic        apb_wr;
  logic        start;

  // Write lands only at the edge that samples pready high
  assign apb_wr = psel && penable && pwrite && pready_r;
  assign start  = apb_wr && paddr == APB_CMD && pwdata[CMD_GO_BIT] &&
                  state_r == H_IDLE;
  assign on_bus = state_r inside {H_CHAN, H_DATA, H_CMD, H_POLL,
                                  H_RESP, H_RDAT, H_CLR};
  assign is_rd  = state_r inside {H_POLL, H_RESP, H_RDAT};
  assign op_end = on_bus && cnt_r == 4'(CYCLE_LEN - 1);
  assign sample = cnt_r == 4'(SETUP_CYC + STROBE_CYC - 1);

  // Register address for each bus step
  always_comb begin
    case (state_r)
      H_CHAN:  op_addr = ADDR_CHANNEL;
      H_DATA:  op_addr = ADDR_DATA;
      H_RDAT:  op_addr = ADDR_DATA;
      H_POLL:  op_addr = ADDR_FLAGS;
      H_CLR:   op_addr = ADDR_FLAGS;
      default: op_addr = ADDR_CMD_RESP;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      H_IDLE: if (start) state_nxt = H_CHAN;
      H_CHAN: if (op_end) state_nxt = cmd_r[CMD_DATA_BIT] ? H_DATA : H_CMD;
      H_DATA: if (op_end) state_nxt = H_CMD;
      H_CMD:  if (op_end) state_nxt = cmd_r[CMD_POLL_BIT] ? H_POLL : H_WAIT;
      H_WAIT: if (!port.attention_pin_n) state_nxt = H_RESP;
      H_POLL: if (op_end) state_nxt = rdat_r[FLAG_RESP] ? H_RESP : H_POLL;
      H_RESP: if (op_end) state_nxt = H_RDAT;
      H_RDAT: if (op_end) state_nxt = H_CLR;
      H_CLR:  if (op_end) state_nxt = H_IDLE;
      default: state_nxt = H_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= H_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Step counter within one strobe cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
    end else if (ce) begin
      cnt_r <= (on_bus && !op_end) ? cnt_r + 4'h1 : 4'h0;
    end
  end

  // Strobe pins, chip select with strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      addr_r <= 2'h0;
      wdat_r <= BYTE_RST;
      oe_r   <= 1'b0;
    end else if (ce) begin
      addr_r <= op_addr;
      oe_r   <= on_bus && !is_rd && !op_end;
      case (state_r)
        H_CHAN:  wdat_r <= cmd_r[15:8];
        H_DATA:  wdat_r <= cmd_r[23:16];
        H_CMD:   wdat_r <= cmd_r[7:0];
        default: wdat_r <= BYTE_RST;
      endcase
      if (on_bus && cnt_r == 4'(SETUP_CYC - 1)) begin
        cs_n_r <= 1'b0;
        wr_n_r <= is_rd;
        rd_n_r <= !is_rd;
      end else if (sample) begin
        cs_n_r <= 1'b1;
        wr_n_r <= 1'b1;
        rd_n_r <= 1'b1;
      end
    end
  end

  // Read data capture and done flag, set wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resp_r <= BYTE_RST;
      rdat_r <= BYTE_RST;
      done_r <= 1'b0;
      cmd_r  <= 32'h0000_0000;
    end else if (ce) begin
      if (start) cmd_r <= pwdata;
      if (on_bus && is_rd && sample) begin
        if (state_r == H_RESP) resp_r <= port.data_bus;
        else rdat_r <= port.data_bus;
      end
      if (apb_wr && paddr == APB_STATUS && pwdata[ST_DONE]) done_r <= 1'b0;
      if (state_r == H_CLR && op_end) done_r <= 1'b1;
    end
  end

  // APB answer one cycle after access phase starts
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      pready_r <= psel && penable && !pready_r;
      case (paddr)
        APB_CMD:    prdata_r <= cmd_r;
        APB_STATUS: prdata_r <= {29'h0, !port.attention_pin_n, done_r,
                                 state_r != H_IDLE};
        APB_RESULT: prdata_r <= {16'h0, rdat_r, resp_r};
        default:    prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = 1'b0;
  assign port.cs_n           = cs_n_r;
  assign port.write_strobe_n = wr_n_r;
  assign port.read_strobe_n  = rd_n_r;
  assign port.reg_addr_low   = addr_r[0];
  assign port.reg_addr_high  = addr_r[1];
  assign port.m_data_out     = wdat_r;
  assign port.m_data_oe      = oe_r;
endmodule

// *** testbench/slave_port_sva.sv ***
// Concurrent checks on the strobe bus joining the two ends
`timescale 1ns/1ps
module slave_port_sva (
  // Clock and reset
  input wire logic       clock,
  input wire logic       arst_n,
  // Strobe bus
  input wire logic       cs_n,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic       reg_addr_low,
  input wire logic       reg_addr_high,
  input wire logic       m_data_oe,
  input wire logic       s_data_oe,
  input wire logic       attention_pin_n,
  input wire logic [7:0] data_bus
);
  logic wr0;
  logic wr3;
  logic rd3;
  logic cmd_pend;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Decoded bus accesses
  assign wr0 = !cs_n && !write_strobe_n && !reg_addr_high && !reg_addr_low;
  assign wr3 = !cs_n && !write_strobe_n && reg_addr_high && reg_addr_low;
  assign rd3 = !cs_n && !read_strobe_n && reg_addr_high && reg_addr_low;

  // Command written and not yet answered
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      cmd_pend <= 1'b0;
    else if (wr0)
      cmd_pend <= 1'b1;
    else if ($fell(attention_pin_n))
      cmd_pend <= 1'b0;
  end

  AST_SEL_WITH_STROBE: // select held
    assert property (!write_strobe_n || !read_strobe_n |-> !cs_n)
    else $error("strobe without chip select");
  AST_ONE_STROBE: // one strobe kind
    assert property (!(!write_strobe_n && !read_strobe_n))
    else $error("both strobes low");
  AST_ADDR_STEADY: // address steady
    assert property (!cs_n && !$past(cs_n) |->
                     $stable({reg_addr_high, reg_addr_low}))
    else $error("address moved during access");
  AST_WRITE_DRIVES: // master drives data
    assert property (!write_strobe_n |-> m_data_oe && !s_data_oe)
    else $error("write without master data");
  AST_READ_ONLY_DRIVE: // answers only reads
    assert property ($rose(s_data_oe) |->
                     !$past(cs_n) && !$past(read_strobe_n))
    else $error("slave drove bus unasked");
  AST_ONE_ANSWER: // one answer per command
    assert property ($fell(attention_pin_n) |-> cmd_pend)
    else $error("attention without command");
  AST_ATTN_HOLD: // low until cleared
    assert property ($rose(attention_pin_n) |->
                     $past(wr3, 2) || $past(wr3, 3) || $past(wr3, 4))
    else $error("attention released without clear");
  AST_ATTN_CLEAR: // clear releases attention
    assert property (wr3 ##1 !wr3 |-> ##[1:4] attention_pin_n)
    else $error("attention not released");
  AST_STATUS_BIT3: // bit 3 tracks response
    assert property (rd3 && $past(rd3) && s_data_oe &&
                     $stable(attention_pin_n) |->
                     data_bus[3] == !attention_pin_n)
    else $error("status bit 3 disagrees");
  AST_RESET_IDLE: // idle after reset
    assert property ($rose(arst_n) |-> attention_pin_n && !s_data_oe)
    else $error("not idle after reset");
endmodule

// *** testbench/tb_top.sv ***
// Bench joining master controller and slave port device
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  err_count++; $display("unexpected at %0t: got %h want %h", \
  $time, a, e); end end
module tb_top;
  import slave_port_pkg::*;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] driver_setup;
  logic poll_service, handler_register, handler_enable, cmd_valid;
  logic cmd_interruptible, resp_valid, resp_has_data;
  logic [7:0] handler_channel, cmd_code, cmd_channel, cmd_data;
  logic [7:0] resp_code, resp_data;
  logic [31:0] q;
  int err_count, total_checks, cycles;

  slave_port_if port_if ();
  slave_port_host u_slave_port_host (.clock(clock), .arst_n(arst_n),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port(port_if));
  slave_port_device u_slave_port_device (.clock(clock), .arst_n(arst_n),
    .ce(1'b1), .port(port_if), .driver_setup(driver_setup),
    .poll_service(poll_service), .handler_register(handler_register),
    .handler_channel(handler_channel), .handler_enable(handler_enable),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_channel(cmd_channel), .cmd_data(cmd_data),
    .cmd_interruptible(cmd_interruptible), .resp_valid(resp_valid),
    .resp_code(resp_code), .resp_data(resp_data),
    .resp_has_data(resp_has_data));
  slave_port_sva u_slave_port_sva (.clock(clock), .arst_n(arst_n),
    .cs_n(port_if.cs_n), .write_strobe_n(port_if.write_strobe_n),
    .read_strobe_n(port_if.read_strobe_n),
    .reg_addr_low(port_if.reg_addr_low),
    .reg_addr_high(port_if.reg_addr_high), .m_data_oe(port_if.m_data_oe),
    .s_data_oe(port_if.s_data_oe),
    .attention_pin_n(port_if.attention_pin_n), .data_bus(port_if.data_bus));

  // Clock source
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected at %0t: run timed out", $time);
      print_verdict();
    end
  end

  // One APB transfer, holds until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask

  // Attach or detach a channel handler
  task attach(input logic [7:0] ch, input logic en);
    handler_channel <= ch; handler_enable <= en; handler_register <= 1'b1;
    @(posedge clock);
    handler_register <= 1'b0;
    @(posedge clock);
  endtask

  // Full command exchange, judged at both user sides
  task run_cmd(input logic [7:0] code, ch, dat, rc, rd,
               input logic hpoll, hand, dup);
    int n;
    apb(1'b1, APB_CMD, {1'b1, 5'h00, hpoll, 1'b1, dat, ch, code});
    if (driver_setup === MODE_POLL) begin
      repeat (30) @(posedge clock); // Command written to slave by now
      `CHK(cmd_valid, 1'b0) // waits for service
      poll_service <= 1'b1;
      @(posedge clock);
      poll_service <= 1'b0;
    end
    if (hand) begin
      n = 0;
      while (cmd_valid !== 1'b1 && n < 100) begin
        @(posedge clock);
        n++;
      end
      `CHK(cmd_valid, 1'b1) // dispatched
      `CHK(cmd_code, code) // command stored
      `CHK(cmd_channel, ch) // channel stored
      `CHK(cmd_data, dat) // data stored
      `CHK(cmd_interruptible, driver_setup === MODE_IRQ)
      if (dup)
        apb(1'b1, APB_CMD, {1'b1, 7'h00, 8'h00, ch, ~code});
      resp_code <= rc; resp_data <= rd; resp_valid <= 1'b1;
      @(posedge clock);
      resp_valid <= 1'b0;
      repeat (2) @(posedge clock);
      `CHK(port_if.attention_pin_n, 1'b0) // answer flagged
    end
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (q[ST_DONE] !== 1'b1 && n < 100);
    `CHK(q[2:0], 3'b010) // done, idle, released
    apb(1'b0, APB_RESULT, 32'h0);
    `CHK(q[7:0], rc) // response read back
    if (hand)
      `CHK(q[15:8], rd) // returned data
    `CHK(port_if.attention_pin_n, 1'b1) // cleared by master
    apb(1'b1, APB_STATUS, 32'h2);
    if (dup) begin
      repeat (30) @(posedge clock);
      `CHK(cmd_valid, 1'b0) // single command seen
    end
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; driver_setup = MODE_IRQ;
    poll_service = 1'b0; handler_register = 1'b0; handler_enable = 1'b0;
    handler_channel = 8'h00; resp_valid = 1'b0; resp_has_data = 1'b1;
    resp_code = 8'h00; resp_data = 8'h00;
    err_count = 0; total_checks = 0; cycles = 0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    `CHK(port_if.attention_pin_n, 1'b1) // released
    `CHK(cmd_valid, 1'b0) // nothing pending
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(q, 32'h0000_0000) // unmapped reads zero
    `CHK(pslverr, 1'b0) // no bus error
    attach(8'h05, 1'b1);
    attach(8'h00, 1'b1);
    run_cmd(8'h01, 8'h05, 8'h41, 8'h01, 8'h5a, 1'b0, 1'b1, 1'b1);
    driver_setup <= MODE_IRQ_NI;
    run_cmd(8'h07, 8'h05, 8'hc3, 8'h02, 8'ha5, 1'b1, 1'b1, 1'b0);
    run_cmd(8'h03, 8'hff, 8'h00, NO_HANDLER_RESP, 8'h00, 1'b0, 1'b0, 1'b0);
    attach(8'h05, 1'b0);
    run_cmd(8'h09, 8'h05, 8'h11, NO_HANDLER_RESP, 8'h00, 1'b1, 1'b0, 1'b0);
    driver_setup <= MODE_POLL;
    run_cmd(8'h0e, 8'h00, 8'h7e, 8'h81, 8'h3c, 1'b1, 1'b1, 1'b0);
    print_verdict();
  end
endmodule
